// [rtl/bsw_pkg.sv]
// shared constants, types and helpers of the switch and sense-wire open diagnostic block
package bsw_pkg;
    localparam int NCELL      = 14;
    localparam int CLK_NS     = 100;
    localparam int SETTLE_NS  = 100000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_W   = $clog2(SETTLE_CYC + 1);

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_BALEN   = 8'h04;
    localparam logic [7:0] OFS_POL     = 8'h08;
    localparam logic [7:0] OFS_MEAS1   = 8'h0c;
    localparam logic [7:0] OFS_MEAS2   = 8'h10;
    localparam logic [7:0] OFS_SCTRL   = 8'h14;
    localparam logic [7:0] OFS_THR     = 8'h18;
    localparam logic [7:0] OFS_ALERT   = 8'h1c;
    localparam logic [7:0] OFS_STAT    = 8'h20;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h24;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h28;
    localparam logic [7:0] OFS_IRQ_EN  = 8'h2c;

    // field positions
    localparam int CTRL_CFG  = 0;
    localparam int CTRL_REQ  = 3;
    localparam int CTRL_ACQ  = 4;
    localparam int CTRL_TOP  = 8;
    localparam int SC_DIAG1  = 0;
    localparam int SC_DIAG2  = 4;
    localparam int SC_ALT    = 8;
    localparam int SC_OVS    = 9;
    localparam int SC_BIP    = 12;
    localparam int THR_LOW   = 0;
    localparam int THR_HIGH  = 16;
    localparam int ALR_SUM   = 16;
    localparam int ST_BUSY   = 0;
    localparam int ST_SETTLD = 1;
    localparam int ST_INACQ  = 2;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ALERT = 1;

    // reset values
    localparam logic [3:0]  RST_TOP   = 4'he;
    localparam logic [12:0] RST_SCTRL = 13'h0000;
    localparam logic [13:0] RST_THR_H = 14'h1fff;

    // scan modes and forced settings
    localparam logic [2:0]  CFG_SWOPEN   = 3'b101;
    localparam logic [2:0]  CFG_ODD      = 3'b110;
    localparam logic [2:0]  CFG_EVEN     = 3'b111;
    localparam logic [13:0] PAT_ODD      = 14'h1555;
    localparam logic [13:0] PAT_EVEN     = 14'h2aaa;
    localparam logic [1:0]  OVR_CSA_BLOCK_VOLTAGE = 2'b00;
    localparam logic [3:0]  OVR_AUX      = 4'b0000;
    localparam logic [3:0]  OVR_DIAG     = 4'h0;
    localparam logic        OVR_ALT      = 1'b1;
    localparam logic [2:0]  OVR_OVS      = 3'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_ACQ} bsw_state_t;

    function automatic logic is_diag(input logic [2:0] mode);
        is_diag = (mode >= CFG_SWOPEN);
    endfunction

    function automatic logic is_swo(input logic [2:0] mode);
        is_swo = (mode == CFG_ODD) || (mode == CFG_EVEN);
    endfunction

    // positions at or below the top position stay live
    function automatic logic [13:0] top_mask(input logic [3:0] top);
        top_mask = 14'((15'h1 << top) - 15'h1);
    endfunction
endpackage

// [rtl/bsw_window_cmp.sv]
// window comparator of one measured switch voltage against low and high thresholds
`timescale 1ns/1ns
module bsw_window_cmp
    import bsw_pkg::*;
(
    input  wire logic [13:0] i_data,
    input  wire logic [13:0] i_low,
    input  wire logic [13:0] i_high,
    output logic             o_outside
);
    // bipolar results, so both sides compare signed
    assign o_outside = ($signed(i_data) < $signed(i_low)) || ($signed(i_data) > $signed(i_high)); // [RULE10]
endmodule

// [rtl/bsw_cfg_override.sv]
// selects forced diagnostic configuration or the user configuration
`timescale 1ns/1ns
module bsw_cfg_override
    import bsw_pkg::*;
(
    input  wire logic        i_active,
    input  wire logic [2:0]  i_mode,
    input  wire logic [3:0]  i_top,
    input  wire logic [13:0] i_polarity,
    input  wire logic [13:0] i_user_bse,
    input  wire logic [15:0] i_user_cme,
    input  wire logic [3:0]  i_user_ame,
    input  wire logic [12:0] i_user_sctrl,
    output logic      [13:0] o_bse,
    output logic      [15:0] o_cme,
    output logic      [3:0]  o_ame,
    output logic      [3:0]  o_diag1,
    output logic      [3:0]  o_diag2,
    output logic             o_alt,
    output logic      [2:0]  o_ovs,
    output logic             o_bipolar
);
    wire        swo     = i_active && is_swo(i_mode);
    wire [13:0] pattern = (i_mode == CFG_ODD) ? PAT_ODD : PAT_EVEN;
    // bus-bar positions and positions above the top are never closed
    wire [13:0] swo_bse = pattern & ~i_polarity & top_mask(i_top);

    assign o_bse     = swo ? swo_bse : i_user_bse; // [RULE4] [RULE5] [RULE8]
    assign o_cme     = i_active ? {OVR_CSA_BLOCK_VOLTAGE, o_bse & ~i_polarity} : i_user_cme; // [RULE1] [RULE6] [RULE7]
    assign o_ame     = i_active ? OVR_AUX : i_user_ame; // [RULE1] [RULE7]
    assign o_diag1   = i_active ? OVR_DIAG : i_user_sctrl[SC_DIAG1 +: 4]; // [RULE2] [RULE7]
    assign o_diag2   = i_active ? OVR_DIAG : i_user_sctrl[SC_DIAG2 +: 4]; // [RULE2] [RULE7]
    assign o_alt     = i_active ? OVR_ALT : i_user_sctrl[SC_ALT]; // [RULE2] [RULE3]
    assign o_ovs     = i_active ? OVR_OVS : i_user_sctrl[SC_OVS +: 3]; // [RULE2] [RULE7]
    assign o_bipolar = i_active ? 1'b1 : i_user_sctrl[SC_BIP]; // [RULE3]
endmodule

// [rtl/bsw_diag_top.sv]
// scan sequencer with apb registers for switch-open and sense-wire-open diagnostics
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// RULE1: switch-open scan measures enabled unipolar switches only
// RULE2: switch-open forces diag off, alt path, one sample
// RULE3: sense-wire scans use bipolar conversion, alternate path
// RULE4: odd pattern 1555h, even pattern 2AAAh
// RULE5: mask bus-bar and above-top switch positions
// RULE6: measure enable equals forced switch and unipolar
// RULE7: sense-wire scan forces other enables and settings
// RULE8: overrides only during scan, then restored
// RULE9: host waits 100us settling before acquisition
// RULE10: outside threshold window sets position alert bit
// RULE11: odd scan leaves even cells unmeasured
// RULE12: open wire alerts only odd cell 2m+1
// RULE13: clear alerts on request, load at end
// RULE14: summary bit is OR of alert vector; here set to that OR at scan end, kept until software or next scan end
// RULE15: alert bit n belongs to position n+1
module bsw_diag_top
    import bsw_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_meas_valid,
    input  wire logic [3:0]  i_meas_index,
    input  wire logic [13:0] i_meas_data,
    input  wire logic        i_scan_done,
    output logic             o_acq_start,
    output logic      [13:0] o_balance_switch_enable,
    output logic      [15:0] o_cell_measure_enable,
    output logic      [3:0]  o_aux_measure_enable,
    output logic      [3:0]  o_diagnostic_select1,
    output logic      [3:0]  o_diagnostic_select2,
    output logic             o_alternate_path_select,
    output logic      [2:0]  o_oversample_rate,
    output logic             o_bipolar_mode,
    output logic             o_irq
);
    bsw_state_t            state;
    logic [2:0]            scan_config;
    logic [2:0]            act_mode;
    logic [3:0]            top_position_setting;
    logic [13:0]           user_bse;
    logic [13:0]           busbar_polarity_bit;
    logic [15:0]           user_cme;
    logic [3:0]            user_ame;
    logic [12:0]           scan_control;
    logic [13:0]           switch_low_threshold;
    logic [13:0]           switch_high_threshold;
    logic [13:0]           switch_alert_vector;
    logic                  switch_alert_summary;
    logic [13:0]           pending;
    logic [SETTLE_W-1:0]   settle_cnt;
    logic [1:0]            irq_status;
    logic [1:0]            irq_enable;
    logic [31:0]           rd_val;
    logic                  cmp_out;
    logic                  ovr_q;
    logic [13:0]           eff_bse;
    logic [15:0]           eff_cme;
    logic [3:0]            eff_ame;
    logic [3:0]            eff_diag1;
    logic [3:0]            eff_diag2;
    logic                  eff_alt;
    logic [2:0]            eff_ovs;
    logic                  eff_bip;

    // apb decode; zero wait states, read data captured in the setup cycle
    wire        wr_en      = i_psel && i_penable && i_pwrite;
    wire        rd_setup   = i_psel && !i_penable && !i_pwrite;
    wire        addr_ok    = (i_paddr[1:0] == 2'b00) && (i_paddr <= OFS_IRQ_EN);
    wire        wr_ctrl    = wr_en && (i_paddr == OFS_CTRL);
    wire        wr_alert   = wr_en && (i_paddr == OFS_ALERT);
    wire        wr_irq_clr = wr_en && (i_paddr == OFS_IRQ_CLR);
    wire [2:0]  new_mode   = i_pwdata[CTRL_CFG +: 3];
    wire        diag_now   = (state != ST_IDLE) && is_diag(act_mode);
    wire        settled    = !is_swo(act_mode) || (settle_cnt == SETTLE_W'(SETTLE_CYC));
    wire        req_go     = wr_ctrl && i_pwdata[CTRL_REQ] && (state == ST_IDLE);
    wire        clr_req    = req_go && is_diag(new_mode);
    wire        acq_go     = wr_ctrl && i_pwdata[CTRL_ACQ] && (state == ST_ARMED) && settled; // [RULE9]
    wire        scan_end   = (state == ST_ACQ) && i_scan_done;
    wire        diag_end   = scan_end && is_diag(act_mode);
    wire [13:0] top_m      = top_mask(top_position_setting);
    wire        idx_ok     = i_meas_index < 4'(NCELL);
    wire [13:0] idx_bit    = idx_ok ? 14'(14'h1 << i_meas_index) : 14'h0; // [RULE15]
    wire        take       = (state == ST_ACQ) && i_meas_valid && cmp_out;
    // only converted positions can raise an alert
    wire [13:0] hit_vec    = take ? (idx_bit & o_cell_measure_enable[13:0]) : 14'h0; // [RULE10] [RULE11]
    wire [13:0] next_alert = (pending | hit_vec) & top_m; // [RULE5] [RULE12]
    wire [1:0]  irq_set    = {diag_end && (|next_alert), scan_end};

    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok;
    assign o_irq     = |(irq_status & irq_enable);

    bsw_window_cmp u_cmp (
        .i_data    (i_meas_data),
        .i_low     (switch_low_threshold),
        .i_high    (switch_high_threshold),
        .o_outside (cmp_out)
    );

    bsw_cfg_override u_ovr (
        .i_active     (diag_now),
        .i_mode       (act_mode),
        .i_top        (top_position_setting),
        .i_polarity   (busbar_polarity_bit),
        .i_user_bse   (user_bse),
        .i_user_cme   (user_cme),
        .i_user_ame   (user_ame),
        .i_user_sctrl (scan_control),
        .o_bse        (eff_bse),
        .o_cme        (eff_cme),
        .o_ame        (eff_ame),
        .o_diag1      (eff_diag1),
        .o_diag2      (eff_diag2),
        .o_alt        (eff_alt),
        .o_ovs        (eff_ovs),
        .o_bipolar    (eff_bip)
    );

    always_comb begin
        rd_val = 32'h0;
        case (i_paddr)
            OFS_CTRL: begin
                rd_val[CTRL_CFG +: 3] = scan_config;
                rd_val[CTRL_TOP +: 4] = top_position_setting;
            end
            OFS_BALEN:  rd_val[13:0] = user_bse;
            OFS_POL:    rd_val[13:0] = busbar_polarity_bit;
            OFS_MEAS1:  rd_val[15:0] = user_cme;
            OFS_MEAS2:  rd_val[3:0]  = user_ame;
            OFS_SCTRL:  rd_val[12:0] = scan_control;
            OFS_THR: begin
                rd_val[THR_LOW +: 14]  = switch_low_threshold;
                rd_val[THR_HIGH +: 14] = switch_high_threshold;
            end
            OFS_ALERT: begin
                rd_val[13:0]    = switch_alert_vector;
                rd_val[ALR_SUM] = switch_alert_summary;
            end
            OFS_STAT: begin
                rd_val[ST_BUSY]   = state != ST_IDLE;
                rd_val[ST_SETTLD] = (state == ST_ARMED) && settled;
                rd_val[ST_INACQ]  = state == ST_ACQ;
            end
            OFS_IRQ_ST: rd_val[1:0] = irq_status;
            OFS_IRQ_EN: rd_val[1:0] = irq_enable;
            default:    rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_prdata <= 32'h0;
        end else if (rd_setup) begin
            o_prdata <= rd_val;
        end
    end

    // user configuration; never altered by the diagnostic, so restore is free
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            scan_config           <= 3'h0;
            top_position_setting  <= RST_TOP;
            user_bse              <= 14'h0;
            busbar_polarity_bit   <= 14'h0;
            user_cme              <= 16'h0;
            user_ame              <= 4'h0;
            scan_control          <= RST_SCTRL;
            switch_low_threshold  <= 14'h0;
            switch_high_threshold <= RST_THR_H;
            irq_enable            <= 2'b00;
        end else if (wr_en) begin
            case (i_paddr)
                OFS_CTRL: begin
                    scan_config          <= new_mode;
                    top_position_setting <= i_pwdata[CTRL_TOP +: 4];
                end
                OFS_BALEN:  user_bse            <= i_pwdata[13:0];
                OFS_POL:    busbar_polarity_bit <= i_pwdata[13:0];
                OFS_MEAS1:  user_cme            <= i_pwdata[15:0];
                OFS_MEAS2:  user_ame            <= i_pwdata[3:0];
                OFS_SCTRL:  scan_control        <= i_pwdata[12:0];
                OFS_THR: begin
                    switch_low_threshold  <= i_pwdata[THR_LOW +: 14];
                    switch_high_threshold <= i_pwdata[THR_HIGH +: 14];
                end
                OFS_IRQ_EN: irq_enable <= i_pwdata[1:0];
                default:    irq_enable <= irq_enable;
            endcase
        end
    end

    // requests outside idle are ignored
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state      <= ST_IDLE;
            act_mode   <= 3'h0;
            settle_cnt <= '0;
            pending    <= 14'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (req_go) begin
                        state      <= ST_ARMED;
                        act_mode   <= new_mode;
                        settle_cnt <= '0;
                        pending    <= 14'h0;
                    end
                end
                ST_ARMED: begin
                    if (!settled) begin
                        settle_cnt <= settle_cnt + 1'b1; // [RULE9]
                    end
                    if (acq_go) begin
                        state <= ST_ACQ;
                    end
                end
                ST_ACQ: begin
                    pending <= pending | hit_vec; // [RULE10]
                    if (i_scan_done) begin
                        state <= ST_IDLE; // [RULE8]
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // a scan end wins over a software clear of the summary
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            switch_alert_vector  <= 14'h0;
            switch_alert_summary <= 1'b0;
        end else if (clr_req) begin
            switch_alert_vector <= 14'h0; // [RULE13]
        end else if (diag_end) begin
            switch_alert_vector  <= next_alert; // [RULE13]
            switch_alert_summary <= |next_alert; // [RULE14]
        end else if (wr_alert && !i_pwdata[ALR_SUM]) begin
            switch_alert_summary <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_status <= 2'b00;
        end else begin
            irq_status <= (irq_status & ~(wr_irq_clr ? i_pwdata[1:0] : 2'b00)) | irq_set;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_acq_start             <= 1'b0;
            ovr_q                   <= 1'b0;
            o_balance_switch_enable <= 14'h0;
            o_cell_measure_enable   <= 16'h0;
            o_aux_measure_enable    <= 4'h0;
            o_diagnostic_select1    <= 4'h0;
            o_diagnostic_select2    <= 4'h0;
            o_alternate_path_select <= 1'b0;
            o_oversample_rate       <= 3'h0;
            o_bipolar_mode          <= 1'b0;
        end else begin
            o_acq_start             <= acq_go;
            ovr_q                   <= diag_now;
            o_balance_switch_enable <= eff_bse;
            o_cell_measure_enable   <= eff_cme;
            o_aux_measure_enable    <= eff_ame;
            o_diagnostic_select1    <= eff_diag1;
            o_diagnostic_select2    <= eff_diag2;
            o_alternate_path_select <= eff_alt;
            o_oversample_rate       <= eff_ovs;
            o_bipolar_mode          <= eff_bip;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_diag_end;
        (state == ST_ACQ) && i_scan_done && is_diag(act_mode);
    endsequence
    sequence s_odd_end;
        s_diag_end ##0 (act_mode == CFG_ODD);
    endsequence

    property p_open_cfg;
        ovr_q && (act_mode == CFG_SWOPEN) |-> (o_cell_measure_enable[15:14] == OVR_CSA_BLOCK_VOLTAGE)
            && (o_aux_measure_enable == OVR_AUX)
            && (o_cell_measure_enable[13:0] == ($past(user_bse) & ~$past(busbar_polarity_bit)));
    endproperty
    a_open_cfg: assert property (p_open_cfg) else $error("open scan enables wrong"); // [RULE1]
    property p_forced_scan;
        ovr_q |-> (o_diagnostic_select1 == OVR_DIAG) && (o_diagnostic_select2 == OVR_DIAG)
            && o_alternate_path_select && (o_oversample_rate == OVR_OVS) && (o_aux_measure_enable == OVR_AUX);
    endproperty
    a_forced_scan: assert property (p_forced_scan) else $error("forced scan settings wrong"); // [RULE2] [RULE7]
    property p_bipolar;
        ovr_q && is_swo(act_mode) |-> o_bipolar_mode && o_alternate_path_select;
    endproperty
    a_bipolar: assert property (p_bipolar) else $error("sense scan not bipolar"); // [RULE3]
    property p_pattern;
        ovr_q && is_swo(act_mode) |-> ((o_balance_switch_enable
            & ~((act_mode == CFG_ODD) ? PAT_ODD : PAT_EVEN)) == 14'h0);
    endproperty
    a_pattern: assert property (p_pattern) else $error("adjacent switch closed"); // [RULE4]
    property p_mask;
        ovr_q && is_swo(act_mode) |-> ((o_balance_switch_enable & $past(busbar_polarity_bit)) == 14'h0)
            && ((o_balance_switch_enable & ~$past(top_m)) == 14'h0);
    endproperty
    a_mask: assert property (p_mask) else $error("masked switch closed"); // [RULE5]
    property p_meas_and;
        ovr_q && is_swo(act_mode) |-> o_cell_measure_enable[13:0]
            == (o_balance_switch_enable & ~$past(busbar_polarity_bit));
    endproperty
    a_meas_and: assert property (p_meas_and) else $error("cell enable mismatch"); // [RULE6] [RULE11]
    property p_restore;
        !ovr_q |-> (o_balance_switch_enable == $past(user_bse)) && (o_cell_measure_enable == $past(user_cme));
    endproperty
    a_restore: assert property (p_restore) else $error("user config not restored"); // [RULE8]
    property p_settle;
        o_acq_start && is_swo(act_mode) |-> $past(settle_cnt) == SETTLE_W'(SETTLE_CYC);
    endproperty
    a_settle: assert property (p_settle) else $error("acquire before settling"); // [RULE9]
    property p_alert_set;
        s_diag_end |=> ((($past(hit_vec) & $past(top_m)) & ~switch_alert_vector) == 14'h0);
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("window hit not flagged"); // [RULE10] [RULE15]
    property p_odd_only;
        s_odd_end |=> ((switch_alert_vector & PAT_EVEN) == 14'h0);
    endproperty
    a_odd_only: assert property (p_odd_only) else $error("odd scan flagged even cell"); // [RULE12]
    property p_clear;
        clr_req |=> (switch_alert_vector == 14'h0) && (state == ST_ARMED);
    endproperty
    a_clear: assert property (p_clear) else $error("alerts not cleared"); // [RULE13]
    property p_summary;
        s_diag_end |=> switch_alert_summary == (|switch_alert_vector);
    endproperty
    a_summary: assert property (p_summary) else $error("summary not OR of alerts"); // [RULE14]
endmodule

// [testbench/bsw_stack_model.sv]
// behavioural cell stack: answers an acquisition with one result per measured position, or per position when i_stray is set
`timescale 1ns/1ns
module bsw_stack_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_acq_start,
    input  wire logic [13:0] i_measure_en,
    input  wire logic [13:0] i_open_fault,
    input  wire logic [13:0] i_fault_high,
    input  wire logic        i_stray,
    input  wire logic [1:0]  i_gap,
    output logic             o_meas_valid,
    output logic      [3:0]  o_meas_index,
    output logic      [13:0] o_meas_data,
    output logic             o_scan_done
);
    int n;
    initial begin
        o_meas_valid = 1'b0;
        o_meas_index = 4'h0;
        o_meas_data  = 14'h0;
        o_scan_done  = 1'b0;
        forever begin
            @(posedge i_sys_clk);
            if (i_acq_start === 1'b1) begin
                for (n = 0; n < 14; n++) begin
                    // stray results on unmeasured positions must be dropped by the device
                    if (i_measure_en[n] || i_stray) begin
                        o_meas_valid <= 1'b1;
                        o_meas_index <= 4'(n);
                        o_meas_data  <= !i_open_fault[n] ? 14'h0800 : i_fault_high[n] ? 14'h1800 : 14'h0010;
                        @(posedge i_sys_clk);
                        // with no gap valid stays up, never dropped and raised in one step
                        if (i_gap != 2'd0) begin
                            o_meas_valid <= 1'b0;
                            o_meas_data  <= ~o_meas_data;
                            repeat (i_gap) @(posedge i_sys_clk);
                        end
                    end
                end
                o_meas_valid <= 1'b0;
                o_scan_done  <= 1'b1;
                @(posedge i_sys_clk);
                o_scan_done <= 1'b0;
            end
        end
    end
endmodule

// [testbench/test_bsw_diag_top.sv]
// self-checking bench of the switch and sense-wire open diagnostic block
`timescale 1ns/1ns
module test_bsw_diag_top import bsw_pkg::*;;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, mv, sd, acq, irq, alt, bip, stray, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  mi, ame, d1, d2, uame;
    logic [13:0] md, bse, fault, fhigh, ubal, upol;
    logic [15:0] cme, ucme;
    logic [12:0] usc;
    logic [2:0]  ovs;
    logic [1:0]  gap;
    int          failures, n_checks, n_acq, seed, i, r;

    bsw_diag_top dut_u (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_meas_valid(mv), .i_meas_index(mi), .i_meas_data(md), .i_scan_done(sd), .o_acq_start(acq),
        .o_balance_switch_enable(bse), .o_cell_measure_enable(cme), .o_aux_measure_enable(ame),
        .o_diagnostic_select1(d1), .o_diagnostic_select2(d2), .o_alternate_path_select(alt),
        .o_oversample_rate(ovs), .o_bipolar_mode(bip), .o_irq(irq));
    bsw_stack_model stack_u (.i_sys_clk(clk), .i_acq_start(acq), .i_measure_en(cme[13:0]), .i_open_fault(fault),
        .i_fault_high(fhigh), .i_stray(stray), .i_gap(gap), .o_meas_valid(mv), .o_meas_index(mi),
        .o_meas_data(md), .o_scan_done(sd));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (acq === 1'b1) n_acq <= n_acq + 1;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            failures++;
            final_report();
        end
    endtask

    // one apb transfer; the request stands until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        tmo(k, 16);
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic scan(input logic [2:0] m, input logic [3:0] t);
        logic [13:0] mask, b, c;
        int          a0, k;
        time         t0;
        mask = 14'((15'h1 << t) - 15'h1);
        b = (m == 3'b110) ? 14'h1555 : (m == 3'b111) ? 14'h2aaa : ubal;
        if (m != 3'b101) b = b & ~upol & mask;
        c = b & ~upol;
        fault <= 14'($random(seed));
        fhigh <= 14'($random(seed));
        gap   <= 2'($random(seed));
        stray <= 1'($random(seed));
        a0 = n_acq;
        xfer(1'b1, OFS_CTRL, {20'h0, t, 4'h0, 1'b1, m});
        t0 = $time;
        xfer(1'b0, OFS_ALERT, 32'h0);
        chk(rd, 64'h0);
        chk({bse, cme, ame, bip, ovs, alt, d2, d1}, {b, 2'b00, c, 4'h0, 1'b1, 3'h0, 1'b1, 8'h00});
        if (m != 3'b101) begin
            // an acquire before the wires have settled is refused
            xfer(1'b1, OFS_CTRL, {20'h0, t, 4'h1, 1'b0, m});
            chk(n_acq - a0, 0);
            for (k = 0; k < 1000; k++) begin
                xfer(1'b0, OFS_STAT, 32'h0);
                if (rd[ST_SETTLD] === 1'b1) break;
            end
            tmo(k, 1000);
            chk($time - t0 >= 100000, 1);
        end
        xfer(1'b1, OFS_CTRL, {20'h0, t, 4'h1, 1'b0, m});
        for (k = 0; k < 200; k++) begin
            @(posedge clk);
            if (irq === 1'b1) break;
        end
        tmo(k, 200);
        chk(n_acq - a0, 1);
        c = fault & c & mask;
        xfer(1'b0, OFS_ALERT, 32'h0);
        chk(rd, {15'h0, |c, 2'b00, c});
        // the summary outlives a new request, so software clears it before the next scan
        xfer(1'b1, OFS_ALERT, 32'h0);
        xfer(1'b0, OFS_ALERT, 32'h0);
        chk(rd, {18'h0, c});
        xfer(1'b0, OFS_IRQ_ST, 32'h0);
        chk(rd, {30'h0, |c, 1'b1});
        xfer(1'b1, OFS_IRQ_EN, 32'h0);
        @(posedge clk);
        chk(irq, 0);
        xfer(1'b1, OFS_IRQ_CLR, 32'h3);
        xfer(1'b1, OFS_IRQ_EN, 32'h3);
        @(posedge clk);
        chk(irq, 0);
        chk({bse, cme, ame, bip, ovs, alt, d2, d1}, {ubal, ucme, uame, usc});
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, fault, fhigh, gap, stray} = '0;
        rst = 1'b1;
        {failures, n_checks, n_acq} = '0;
        seed = 32'h421d1407;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0e00);
        xfer(1'b0, OFS_THR, 32'h0);
        chk(rd, 32'h1fff_0000);
        xfer(1'b0, 8'h30, 32'h0);
        chk({e, rd}, {1'b1, 32'h0});
        xfer(1'b1, OFS_THR, {2'b0, 14'h1000, 2'b0, 14'h0100});
        xfer(1'b1, OFS_IRQ_EN, 32'h3);
        for (r = 0; r < 4; r++) begin
            ubal = 14'($random(seed));
            // first round keeps every position unipolar, later rounds mix in bus bars
            upol = (r == 0) ? 14'h0 : 14'($random(seed));
            ucme = 16'($random(seed));
            uame = 4'($random(seed));
            usc  = 13'($random(seed));
            xfer(1'b1, OFS_BALEN, {18'h0, ubal});
            xfer(1'b1, OFS_POL, {18'h0, upol});
            xfer(1'b1, OFS_MEAS1, {16'h0, ucme});
            xfer(1'b1, OFS_MEAS2, {28'h0, uame});
            xfer(1'b1, OFS_SCTRL, {19'h0, usc});
            for (i = 0; i < 3; i++)
                scan(3'(5 + i), (i == 0 || r == 0) ? 4'he : 4'({$random(seed)} % 14 + 1));
        end
        final_report();
    end
endmodule
